//--- logic/misc_status_control_regs.sv
`timescale 1ns/1ps
`include "misc_regs_map.svh"
module misc_status_control_regs #(
  // Value is arbitrary
  parameter logic [31:0] ID_CODE = 32'h00000A01,
  parameter int PIN_SYNC_STAGES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`EXT_HI:`EXT_LO] ext_irq_event,
  input wire logic boot_watchdog,
  input wire logic boot_wakeup,
  input wire misc_regs_pkg::pin_level_s pins_async,
  output logic irq,
  output logic pad_ctrl_en,
  output misc_regs_pkg::pad_drive_s pad_drive
);

  localparam int PIN_W = $bits(misc_regs_pkg::pin_level_s);
  localparam int PIN_LAT = PIN_SYNC_STAGES;

  generate
    if (PIN_SYNC_STAGES < 2) begin : g_bad_sync
      $error("PIN_SYNC_STAGES must be at least 2");
    end
  endgenerate

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : strb_mask

  function automatic misc_regs_pkg::reg_id_e decode(input logic [31:0] a);
    case (a)
      `ADDR_EXT_IRQ_MASK: decode = misc_regs_pkg::REG_MASK;
      `ADDR_EXT_IRQ_PENDING: decode = misc_regs_pkg::REG_PEND;
      `ADDR_PIN_LEVEL_STATUS: decode = misc_regs_pkg::REG_PINS;
      `ADDR_PART_IDENTITY: decode = misc_regs_pkg::REG_IDENT;
      `ADDR_RESET_CAUSE: decode = misc_regs_pkg::REG_CAUSE;
      `ADDR_SCRATCH_KEEP_A: decode = misc_regs_pkg::REG_SCR_A;
      `ADDR_SCRATCH_KEEP_B: decode = misc_regs_pkg::REG_SCR_B;
      `ADDR_PAD_STRENGTH_A: decode = misc_regs_pkg::REG_PAD_A;
      `ADDR_PAD_STRENGTH_B: decode = misc_regs_pkg::REG_PAD_B;
      default: decode = misc_regs_pkg::REG_NONE;
    endcase
  endfunction : decode

  // Strongest at 00, then one step weaker per rank 10, 01, 11
  function automatic logic [3:0] drive_ma(input logic [1:0] code,
                                          input logic [3:0] top);
    case (code)
      2'b00: drive_ma = top;
      2'b10: drive_ma = top - `DRV_STEP;
      2'b01: drive_ma = top - `DRV_STEP - `DRV_STEP;
      default: drive_ma = top - `DRV_STEP - `DRV_STEP - `DRV_STEP;
    endcase
  endfunction : drive_ma

  misc_regs_pkg::reg_id_e sel;
  logic setup_rd;
  logic wr_en;
  logic [31:0] wm;
  logic [31:0] wdata_m;
  logic [`EXT_HI:`EXT_LO] pend_reg;
  logic [`EXT_HI:`EXT_LO] mask_reg;
  logic [`EXT_HI:`EXT_LO] pend_clr;
  logic [31:0] pend_word;
  logic [31:0] mask_word;
  logic [PIN_SYNC_STAGES-1:0][PIN_W-1:0] pin_sync_reg;
  logic [`CAUSE_WDT:`CAUSE_POR] cause_reg;
  logic [`CAUSE_WDT:`CAUSE_POR] cause_set;
  logic [`CAUSE_WDT:`CAUSE_POR] cause_clr;
  logic boot_done_reg;
  logic [31:0] scratch_a_reg;
  logic [31:0] scratch_b_reg;
  logic [31:0] pad_a_reg;
  logic [31:0] pad_b_reg;
  misc_regs_pkg::pad_a_s pad_a_f;
  misc_regs_pkg::pad_b_s pad_b_f;
  misc_regs_pkg::pad_drive_s drive_next;
  logic [31:0] rd_data;
  logic [31:0] prdata_reg;

  // Bus decode and zero-wait answer
  assign sel = decode(paddr);
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = psel & penable & pwrite;
  assign wm = strb_mask(pstrb);
  assign wdata_m = pwdata & wm;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == misc_regs_pkg::REG_NONE);
  assign prdata = prdata_reg;

  // External interrupt pending and mask
  always_comb begin
    pend_clr = '0;
    if (wr_en && sel == misc_regs_pkg::REG_PEND) begin
      pend_clr = wdata_m[`EXT_HI:`EXT_LO];
    end
  end

  // A new event wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= `PEND_RST;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | ext_irq_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `MASK_RST;
    end else if (wr_en && sel == misc_regs_pkg::REG_MASK) begin
      mask_reg <= (mask_reg & ~wm[`EXT_HI:`EXT_LO]) |
                  wdata_m[`EXT_HI:`EXT_LO];
    end
  end

  always_comb begin
    pend_word = '0;
    mask_word = '0;
    pend_word[`EXT_HI:`EXT_LO] = pend_reg;
    mask_word[`EXT_HI:`EXT_LO] = mask_reg;
  end

  assign irq = |(pend_reg & ~mask_reg);

  // Pins are asynchronous; only the last stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= '0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[PIN_SYNC_STAGES-2:0], pins_async};
    end
  end

  // Reset cause: cause levels are caught at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done_reg <= 1'b0;
    end else begin
      boot_done_reg <= 1'b1;
    end
  end

  always_comb begin
    cause_set = '0;
    cause_clr = '0;
    if (!boot_done_reg) begin
      cause_set[`CAUSE_WDT] = boot_watchdog;
      cause_set[`CAUSE_WAKE] = boot_wakeup;
    end
    if (wr_en && sel == misc_regs_pkg::REG_CAUSE) begin
      cause_clr = wdata_m[`CAUSE_WDT:`CAUSE_POR];
    end
  end

  // Held on power-on reset only, so a warm reset keeps the evidence
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cause_reg <= `CAUSE_RST;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;
    end
  end

  // Scratch words survive every reset but power-on
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      scratch_a_reg <= `SCRATCH_RST;
    end else if (wr_en && sel == misc_regs_pkg::REG_SCR_A) begin
      scratch_a_reg <= (scratch_a_reg & ~wm) | wdata_m;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      scratch_b_reg <= `SCRATCH_RST;
    end else if (wr_en && sel == misc_regs_pkg::REG_SCR_B) begin
      scratch_b_reg <= (scratch_b_reg & ~wm) | wdata_m;
    end
  end

  // Drive strength registers; reserved bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_a_reg <= `PAD_RST;
    end else if (wr_en && sel == misc_regs_pkg::REG_PAD_A) begin
      pad_a_reg <= (pad_a_reg & ~wm) | (wdata_m & `PAD_A_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_b_reg <= `PAD_RST;
    end else if (wr_en && sel == misc_regs_pkg::REG_PAD_B) begin
      pad_b_reg <= (pad_b_reg & ~wm) | (wdata_m & `PAD_B_WMASK);
    end
  end

  assign pad_a_f = misc_regs_pkg::pad_a_s'(pad_a_reg);
  assign pad_b_f = misc_regs_pkg::pad_b_s'(pad_b_reg);

  // Codes not listed for a pad follow the same one-step ladder
  always_comb begin
    drive_next = '0;
    drive_next.addr_ma = drive_ma(pad_a_f.addr_bus_strength, `DRV_TOP_HI);
    for (int l = 0; l < 4; l++) begin
      drive_next.data_ma[l] = drive_ma(pad_a_f.data_lane_strength[l],
                                       `DRV_TOP_HI);
    end
    drive_next.clk1_ma = drive_ma(pad_b_f.mem_clk1_strength, `DRV_TOP_HI);
    drive_next.clk0_ma = drive_ma(pad_b_f.mem_clk0_strength, `DRV_TOP_HI);
    drive_next.clk_en_ma = drive_ma(pad_b_f.mem_clk_en_strength, `DRV_TOP_LO);
    drive_next.row_col_ma = drive_ma(pad_b_f.row_col_strobe_strength,
                                     `DRV_TOP_LO);
    drive_next.flash_ctrl_ma = drive_ma(pad_b_f.flash_ctrl_strength,
                                        `DRV_TOP_LO);
    drive_next.byte_en_ma = drive_ma(pad_b_f.byte_en_strength, `DRV_TOP_LO);
    drive_next.wr_oe_ma = drive_ma(pad_b_f.wr_oe_strength, `DRV_TOP_LO);
    for (int c = 0; c < 8; c++) begin
      drive_next.cs_ma[c] = drive_ma(pad_b_f.chip_sel_strength[c],
                                     `DRV_TOP_LO);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_drive <= '0;
      pad_ctrl_en <= 1'b0;
    end else begin
      pad_drive <= drive_next;
      pad_ctrl_en <= ~pad_a_f.strength_ctrl_disable_n;
    end
  end

  // Read data is registered in the setup cycle
  always_comb begin
    rd_data = '0;
    case (sel)
      misc_regs_pkg::REG_MASK: rd_data = mask_word;
      misc_regs_pkg::REG_PEND: rd_data = pend_word;
      misc_regs_pkg::REG_PINS: rd_data[PIN_W-1:0] = pin_sync_reg[PIN_SYNC_STAGES-1];
      misc_regs_pkg::REG_IDENT: rd_data = ID_CODE;
      misc_regs_pkg::REG_CAUSE: rd_data[`CAUSE_WDT:`CAUSE_POR] = cause_reg;
      misc_regs_pkg::REG_SCR_A: rd_data = scratch_a_reg;
      misc_regs_pkg::REG_SCR_B: rd_data = scratch_b_reg;
      misc_regs_pkg::REG_PAD_A: rd_data = pad_a_reg;
      misc_regs_pkg::REG_PAD_B: rd_data = pad_b_reg;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= rd_data;
    end
  end

  a_pend_event_set: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_irq_event != '0) |=>
      ((pend_reg & $past(ext_irq_event)) == $past(ext_irq_event)))
    else $error("pending bit missed its event");

  a_pend_w1c_exact: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == misc_regs_pkg::REG_PEND && ext_irq_event == '0) |=>
      (pend_reg == ($past(pend_reg) & ~$past(pend_clr))))
    else $error("pending clear wrong");

  a_pend_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && sel == misc_regs_pkg::REG_PEND) |=>
      (prdata[`EXT_LO-1:0] == '0) && (prdata[`EXT_HI:`EXT_LO] == $past(pend_reg)))
    else $error("pending read wrong");

  a_mask_blocks_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ((pend_reg & ~mask_reg) == '0) |-> !irq)
    else $error("masked line raised irq");

  a_pin_level_path: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, PIN_LAT) |->
      (pin_sync_reg[PIN_SYNC_STAGES-1] == $past(pins_async, PIN_LAT)))
    else $error("pin level path wrong");

  a_cause_wdt_clear: assert property (@(posedge pclk)
    disable iff (!por_n || !presetn)
    (wr_en && sel == misc_regs_pkg::REG_CAUSE && boot_done_reg &&
     pwdata[`CAUSE_WDT] && pstrb[0]) |=> !cause_reg[`CAUSE_WDT])
    else $error("watchdog flag not cleared");

  a_cause_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!boot_done_reg && boot_wakeup) |=> cause_reg[`CAUSE_WAKE] ##1 boot_done_reg)
    else $error("wakeup cause not caught");

  a_cause_por_set: assert property (@(posedge pclk) disable iff (!por_n)
    !$past(por_n) |-> cause_reg[`CAUSE_POR])
    else $error("power-on flag not set");

  a_scratch_kept: assert property (@(posedge pclk) disable iff (!por_n)
    !presetn |=> $stable(scratch_a_reg) && $stable(scratch_b_reg))
    else $error("scratch lost on warm reset");

  a_strength_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(pad_a_f.strength_ctrl_disable_n) |=>
      (pad_ctrl_en == !$past(pad_a_f.strength_ctrl_disable_n)))
    else $error("strength enable wrong");

  a_clk1_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_b_f.mem_clk1_strength == 2'b01) |=> (pad_drive.clk1_ma == 4'h8))
    else $error("clock 1 strength decode wrong");

  a_cs5_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_b_f.chip_sel_strength[5] == 2'b11) |=> (pad_drive.cs_ma[5] == 4'h4))
    else $error("chip select 5 decode wrong");

  a_pad_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (pad_a_reg == '0) && (pad_b_reg == '0) ##1
      (pad_drive.addr_ma == 4'hC) && pad_ctrl_en)
    else $error("strength reset wrong");

  a_ident_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && sel == misc_regs_pkg::REG_IDENT) |=> (prdata == ID_CODE))
    else $error("identity read wrong");

  a_irq_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
    ((pend_reg & ~mask_reg) != '0) |-> irq)
    else $error("unmasked pending line gave no irq");

  a_pend_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_irq_event == '0) |=> ((pend_reg & ~$past(pend_reg)) == '0))
    else $error("pending bit rose without event");

  // A zero in the write word must keep a pending bit that is already set
  a_pend_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == misc_regs_pkg::REG_PEND) |=>
      ((pend_reg & $past(pend_reg) & ~$past(pend_clr)) ==
       ($past(pend_reg) & ~$past(pend_clr))))
    else $error("pending bit lost on zero write");

  a_cause_hold: assert property (@(posedge pclk)
    disable iff (!por_n || !presetn)
    (boot_done_reg && !(wr_en && sel == misc_regs_pkg::REG_CAUSE)) |=>
      (cause_reg == $past(cause_reg)))
    else $error("reset cause changed without a write");

  a_pad_a_store: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == misc_regs_pkg::REG_PAD_A && pstrb == 4'hF) |=>
      (pad_a_reg == ($past(pwdata) & `PAD_A_WMASK)))
    else $error("strength word A stored wrong");

  a_addr_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_a_f.addr_bus_strength == 2'b00) |=> (pad_drive.addr_ma == 4'hC))
    else $error("address strength decode wrong");

  a_clk0_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_b_f.mem_clk0_strength == 2'b11) |=> (pad_drive.clk0_ma == 4'h6))
    else $error("clock 0 strength decode wrong");

  a_ctl_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_b_f.wr_oe_strength == 2'b11) |=> (pad_drive.wr_oe_ma == 4'h4))
    else $error("write enable strength decode wrong");

endmodule : misc_status_control_regs

//--- logic/misc_regs_map.svh
`ifndef MISC_REGS_MAP_SVH
`define MISC_REGS_MAP_SVH

`define ADDR_EXT_IRQ_MASK 32'h560000A4
`define ADDR_EXT_IRQ_PENDING 32'h560000A8
`define ADDR_PIN_LEVEL_STATUS 32'h560000AC
`define ADDR_PART_IDENTITY 32'h560000B0
`define ADDR_RESET_CAUSE 32'h560000B4
`define ADDR_SCRATCH_KEEP_A 32'h560000B8
`define ADDR_SCRATCH_KEEP_B 32'h560000BC
`define ADDR_PAD_STRENGTH_A 32'h560000C4
`define ADDR_PAD_STRENGTH_B 32'h560000C8

`define EXT_LO 4
`define EXT_HI 23
`define PEND_RST 20'h00000
`define MASK_RST 20'hFFFFF
`define CAUSE_POR 0
`define CAUSE_WAKE 1
`define CAUSE_WDT 2
`define CAUSE_RST 3'h1
`define SCRATCH_RST 32'h00000000
`define PAD_RST 32'h00000000
`define PAD_A_WMASK 32'h800003FF
`define PAD_B_WMASK 32'h3FFFFFFF
`define DRV_TOP_HI 4'hC
`define DRV_TOP_LO 4'hA
`define DRV_STEP 4'h2
`endif

//--- logic/misc_regs_pkg.sv
package misc_regs_pkg;
  typedef struct packed {
    logic wait_input;
    logic flash_config_pin;
    logic flash_ready_busy;
    logic battery_fault_pin;
  } pin_level_s;
  typedef struct packed {
    logic strength_ctrl_disable_n;
    logic [20:0] rsvd;
    logic [1:0] addr_bus_strength;
    logic [3:0][1:0] data_lane_strength;
  } pad_a_s;
  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] mem_clk1_strength;
    logic [1:0] mem_clk0_strength;
    logic [1:0] mem_clk_en_strength;
    logic [1:0] row_col_strobe_strength;
    logic [1:0] flash_ctrl_strength;
    logic [1:0] byte_en_strength;
    logic [1:0] wr_oe_strength;
    logic [7:0][1:0] chip_sel_strength;
  } pad_b_s;
  typedef struct packed {
    logic [3:0] addr_ma;
    logic [3:0][3:0] data_ma;
    logic [3:0] clk1_ma;
    logic [3:0] clk0_ma;
    logic [3:0] clk_en_ma;
    logic [3:0] row_col_ma;
    logic [3:0] flash_ctrl_ma;
    logic [3:0] byte_en_ma;
    logic [3:0] wr_oe_ma;
    logic [7:0][3:0] cs_ma;
  } pad_drive_s;
  typedef enum logic [3:0] {
    REG_NONE, REG_MASK, REG_PEND, REG_PINS, REG_IDENT,
    REG_CAUSE, REG_SCR_A, REG_SCR_B, REG_PAD_A, REG_PAD_B
  } reg_id_e;
endpackage : misc_regs_pkg

//--- verif/misc_status_control_regs_tb.sv
`timescale 1ns/1ps
`include "misc_regs_map.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t %s", $time, msg); end end
module misc_status_control_regs_tb;
  // Value is arbitrary
  localparam logic [31:0] ID = 32'h00000A01;
  logic pclk, presetn, por_n, psel, penable, pwrite, boot_watchdog, boot_wakeup;
  logic [31:0] paddr, pwdata, prdata, v, w;
  logic [3:0] pstrb;
  logic pready, pslverr, irq, pad_ctrl_en;
  logic [23:4] ext_irq_event;
  logic [1:0] c;
  misc_regs_pkg::pin_level_s pins_async;
  misc_regs_pkg::pad_drive_s pad_drive;
  logic [32:0] exp_q[$];
  logic [32:0] mon_e;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int ln;
  integer seed = 32'h88DF;

  misc_status_control_regs #(.ID_CODE(ID), .PIN_SYNC_STAGES(2)) i_misc_status_control_regs (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_event(ext_irq_event),
    .boot_watchdog(boot_watchdog), .boot_wakeup(boot_wakeup), .pins_async(pins_async),
    .irq(irq), .pad_ctrl_en(pad_ctrl_en), .pad_drive(pad_drive));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  // Every completed transfer consumes the oldest expectation
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected transfer")
      else begin
        mon_e = exp_q.pop_front();
        if (pwrite) `CHK(pslverr, mon_e[32], "write response")
        else `CHK({pslverr, prdata}, mon_e, "read data")
      end
    end
  end

  task automatic apb(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    exp_q.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b1, a, d, {er, 32'h00000000});
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic er = 1'b0);
    apb(1'b0, a, 32'h00000000, {er, e});
  endtask : rd

  task automatic rst(input logic por, input logic wdt, input logic wak);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~por;
    boot_watchdog <= wdt;
    boot_wakeup <= wak;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    // Causes are captured at every edge while presetn is low with por_n high, and at the first edge after release
    repeat (2) @(posedge pclk);
    boot_watchdog <= 1'b0;
    boot_wakeup <= 1'b0;
  endtask : rst

  function automatic logic [3:0] ma(input logic [3:0] top, input logic [1:0] code);
    case (code)
      2'b00: ma = top;
      2'b10: ma = top - 4'h2;
      2'b01: ma = top - 4'h4;
      default: ma = top - 4'h6;
    endcase
  endfunction : ma

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pstrb = 4'hF; presetn = 1'b0; por_n = 1'b0; boot_watchdog = 1'b0; boot_wakeup = 1'b0;
    ext_irq_event = '0; pins_async = '0;
    rst(1'b1, 1'b0, 1'b0);
    rd(`ADDR_EXT_IRQ_MASK, 32'h00FFFFF0);
    rd(`ADDR_EXT_IRQ_PENDING, 32'h0);
    rd(`ADDR_RESET_CAUSE, 32'h1);
    rd(`ADDR_SCRATCH_KEEP_A, 32'h0);
    rd(`ADDR_SCRATCH_KEEP_B, 32'h0);
    rd(`ADDR_PAD_STRENGTH_A, 32'h0);
    rd(`ADDR_PAD_STRENGTH_B, 32'h0);
    rd(`ADDR_PART_IDENTITY, ID);
    @(negedge pclk);
    `CHK(pad_ctrl_en, 1'b1, "strength enable after reset")
    $display("test reset_values done");
    wr(`ADDR_PART_IDENTITY, ~ID);
    rd(`ADDR_PART_IDENTITY, ID);
    wr(`ADDR_PIN_LEVEL_STATUS, 32'hFFFFFFFF);
    rd(`ADDR_PIN_LEVEL_STATUS, 32'h0);
    wr(32'h560000C0, $random(seed), 1'b1);
    rd(32'h560000C0, 32'h0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      @(posedge pclk);
      pins_async <= misc_regs_pkg::pin_level_s'(v[3:0]);
      repeat (4) @(posedge pclk);
      rd(`ADDR_PIN_LEVEL_STATUS, {28'h0, v[3:0]});
    end
    $display("test refusals_pins done");
    wr(`ADDR_EXT_IRQ_MASK, 32'h0);
    @(posedge pclk);
    ext_irq_event <= '1;
    @(posedge pclk);
    ext_irq_event <= '0;
    rd(`ADDR_EXT_IRQ_PENDING, 32'h00FFFFF0);
    wr(`ADDR_EXT_IRQ_PENDING, 32'hFFFFFFFF);
    rd(`ADDR_EXT_IRQ_PENDING, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ln = 4 + ({$random(seed)} % 20);
      w = 32'h1 << ln;
      @(posedge pclk);
      ext_irq_event[ln] <= 1'b1;
      @(posedge pclk);
      ext_irq_event[ln] <= 1'b0;
      @(negedge pclk);
      `CHK(irq, 1'b1, "irq on unmasked event")
      wr(`ADDR_EXT_IRQ_PENDING, ~w);
      rd(`ADDR_EXT_IRQ_PENDING, w);
      wr(`ADDR_EXT_IRQ_MASK, w);
      @(negedge pclk);
      `CHK(irq, 1'b0, "irq while masked")
      @(posedge pclk);
      ext_irq_event[ln] <= 1'b1;
      wr(`ADDR_EXT_IRQ_PENDING, w);
      ext_irq_event[ln] <= 1'b0;
      rd(`ADDR_EXT_IRQ_PENDING, w);
      wr(`ADDR_EXT_IRQ_PENDING, w);
      rd(`ADDR_EXT_IRQ_PENDING, 32'h0);
      wr(`ADDR_EXT_IRQ_MASK, 32'h0);
    end
    $display("test events done");
    v = $random(seed);
    w = $random(seed);
    wr(`ADDR_SCRATCH_KEEP_A, v);
    wr(`ADDR_SCRATCH_KEEP_B, w);
    wr(`ADDR_RESET_CAUSE, 32'h0);
    rd(`ADDR_RESET_CAUSE, 32'h1);
    wr(`ADDR_RESET_CAUSE, 32'h1);
    rd(`ADDR_RESET_CAUSE, 32'h0);
    rst(1'b0, 1'b1, 1'b0);
    rd(`ADDR_RESET_CAUSE, 32'h4);
    rd(`ADDR_SCRATCH_KEEP_A, v);
    rd(`ADDR_SCRATCH_KEEP_B, w);
    wr(`ADDR_RESET_CAUSE, 32'h4);
    rd(`ADDR_RESET_CAUSE, 32'h0);
    rst(1'b0, 1'b0, 1'b1);
    rd(`ADDR_RESET_CAUSE, 32'h2);
    wr(`ADDR_RESET_CAUSE, 32'h2);
    rd(`ADDR_RESET_CAUSE, 32'h0);
    rst(1'b1, 1'b0, 1'b0);
    rd(`ADDR_RESET_CAUSE, 32'h1);
    rd(`ADDR_SCRATCH_KEEP_A, 32'h0);
    pstrb <= 4'h6;
    wr(`ADDR_SCRATCH_KEEP_A, v);
    pstrb <= 4'hF;
    rd(`ADDR_SCRATCH_KEEP_A, v & 32'h00FFFF00);
    $display("test reset_causes done");
    v = $random(seed);
    wr(`ADDR_PAD_STRENGTH_A, v);
    rd(`ADDR_PAD_STRENGTH_A, v & `PAD_A_WMASK);
    @(negedge pclk);
    `CHK(pad_ctrl_en, ~v[31], "strength enable follows bit 31")
    w = $random(seed);
    wr(`ADDR_PAD_STRENGTH_B, w);
    rd(`ADDR_PAD_STRENGTH_B, w & `PAD_B_WMASK);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(`ADDR_PAD_STRENGTH_A, {1'b1, 21'h0, {5{c}}});
      wr(`ADDR_PAD_STRENGTH_B, {2'b00, {15{c}}});
      repeat (2) @(negedge pclk);
      `CHK(pad_ctrl_en, 1'b0, "strength disabled")
      `CHK(pad_drive.clk1_ma, ma(4'hC, c), "clk1 mA")
      `CHK(pad_drive.clk0_ma, ma(4'hC, c), "clk0 mA")
      `CHK({pad_drive.cs_ma[5], pad_drive.cs_ma[2]}, {2{ma(4'hA, c)}}, "cs mA")
      `CHK({pad_drive.clk_en_ma, pad_drive.wr_oe_ma}, {2{ma(4'hA, c)}}, "ctl mA")
      `CHK({pad_drive.cs_ma[7], pad_drive.cs_ma[0]}, {2{ma(4'hA, c)}}, "cs0 mA")
      `CHK({pad_drive.addr_ma, pad_drive.data_ma}, {5{ma(4'hC, c)}}, "bus mA")
      `CHK({pad_drive.cs_ma[4], pad_drive.cs_ma[3]}, {2{ma(4'hA, c)}}, "cs4 mA")
      `CHK({pad_drive.row_col_ma, pad_drive.byte_en_ma}, {2{ma(4'hA, c)}}, "rc mA")
      `CHK({pad_drive.flash_ctrl_ma, pad_drive.cs_ma[6]}, {2{ma(4'hA, c)}}, "nf mA")
      `CHK(pad_drive.cs_ma[1], ma(4'hA, c), "cs1 mA")
    end
    $display("test pad_strength done");
    results();
  end
endmodule : misc_status_control_regs_tb
